// *** rtl/gpib_listener_pkg.sv ***
package gpib_listener_pkg;

    // clock rate and timing figures
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned SETTLE_MIN_NS  = 2000;   // least settling after data valid
    localparam int unsigned SETTLE_MAX_NS  = 3000;   // longest settling after data valid
    localparam int unsigned STROBE_NS      = 300;    // strobe width
    localparam int unsigned SETTLE_CYCLES  = (SETTLE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STROBE_CYCLES  = (STROBE_NS * CLK_MHZ) / 1000;

    // bus character codes (7-bit, true sense)
    localparam logic [6:0] CHAR_UNLISTEN   = 7'h3f;  // '?'
    localparam logic [6:0] CHAR_REMOTE_MK  = 7'h52;  // 'R'
    localparam logic [6:0] CHAR_LOCAL_MK   = 7'h4c;  // 'L'
    localparam logic [6:0] CHAR_MODE       = 7'h4d;  // 'M'
    localparam logic [6:0] CHAR_DIGIT1     = 7'h31;  // '1'
    localparam logic [6:0] CHAR_DIGIT4     = 7'h34;  // '4'
    localparam logic [1:0] LISTEN_GROUP    = 2'b01;  // bits 6:5 of a listen character

    // register map, byte addresses
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_STATUS      = 4'h4;
    localparam logic [3:0] REG_DATA        = 4'h8;

    // field positions
    localparam int unsigned CTRL_ADDR_LSB  = 0;      // listen address, 5 bits
    localparam int unsigned ST_LISTEN      = 0;
    localparam int unsigned ST_REMOTE      = 1;
    localparam int unsigned ST_MARKER      = 2;
    localparam int unsigned ST_MODE_EN     = 3;
    localparam int unsigned ST_TUNE_EN     = 4;
    localparam int unsigned ST_FIFO_VALID  = 5;

    // reset values
    localparam logic [4:0] CTRL_ADDR_RST   = 5'h00;
    localparam logic [3:0] MODE_SEL_RST_N  = 4'hf;

    // acceptor handshake states
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SETTLE,
        HS_ACCEPTED
    } hs_state_t;

endpackage

// *** rtl/char_stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries accepted data characters from the acceptor's byte latch into the buffer
interface char_stream_if #(
    parameter int unsigned W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/char_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module char_fifo
    import gpib_listener_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    char_stream_if.sink           in_if,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_state_t;

    fifo_state_t       s_q;
    fifo_state_t       s_d;
    logic [WIDTH-1:0]  mem_q [DEPTH];
    logic              push;
    logic              pop;

    // honest full and empty come straight from the count
    assign in_if.ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_q.cnt != '0);
    assign out_data_o  = mem_q[s_q.rd];
    assign push        = in_if.valid && in_if.ready;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
        end
        case ({push, pop})
            2'b10:   s_d.cnt = s_q.cnt + (AW+1)'(1);
            2'b01:   s_d.cnt = s_q.cnt - (AW+1)'(1);
            default: s_d.cnt = s_q.cnt;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // storage has no reset; the count guards it
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[s_q.wr] <= in_if.data;
        end
    end
endmodule
`default_nettype wire

// *** rtl/char_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module char_decoder
    import gpib_listener_pkg::*;
(
    // bus view, true sense
    input  wire logic       atn_i,
    input  wire logic [6:0] char_i,
    input  wire logic [4:0] my_addr_i,
    // decoded lines
    output logic            addr_match_o,
    output logic            listen_o,
    output logic            unlisten_o,
    output logic            remote_mk_o,
    output logic            local_mk_o,
    output logic            mode_o,
    output logic            digit_o,
    output logic [3:0]      mode_onehot_o
);
    logic in_digit;

    // command mode: only address, listen and unlisten may be true
    assign addr_match_o = atn_i && (char_i[4:0] == my_addr_i);          // RULE_17
    assign listen_o     = atn_i && (char_i[6:5] == LISTEN_GROUP)
                        && (char_i != CHAR_UNLISTEN);                   // RULE_18
    assign unlisten_o   = atn_i && (char_i == CHAR_UNLISTEN);           // RULE_18
    // data mode: one line per character
    assign remote_mk_o  = !atn_i && (char_i == CHAR_REMOTE_MK);         // RULE_19
    assign local_mk_o   = !atn_i && (char_i == CHAR_LOCAL_MK);          // RULE_19
    assign mode_o       = !atn_i && (char_i == CHAR_MODE);              // RULE_19
    assign in_digit     = (char_i >= CHAR_DIGIT1) && (char_i <= CHAR_DIGIT4);
    assign digit_o      = !atn_i && in_digit;                           // RULE_19

    // one-hot decode of the mode digit
    always_comb begin
        mode_onehot_o = 4'h0;
        if (digit_o) begin
            mode_onehot_o[char_i[1:0] - 2'd1] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** rtl/gpib_listener.sv ***
// Operation
// RULE_01: handshake enabled under ATN or while listening
// RULE_02: drive NRFD/NDAC only when enabled; invert data
// RULE_03: settle after DAV, then accept byte
// RULE_04: hold until DAV false, then release
// RULE_05: controller holds DAV until all accept
// RULE_06: short data strobe times every transfer
// RULE_07: strobe sets or clears listen state
// RULE_08: IFC low clears listen at once
// RULE_09: REN true with match or strobe: remote
// RULE_10: only REN false returns to local
// RULE_11: R sets marker, L clears it
// RULE_12: local clears marker; output inverted enable
// RULE_13: mode select held off until delayed strobe
// RULE_14: captured M forms delayed strobe
// RULE_15: digit after M drives one mode line
// RULE_16: digit 1-4 on delayed strobe enables tuning
// RULE_17: five-bit address compare under ATN
// RULE_18: command mode decodes listen and unlisten
// RULE_19: data mode decodes one line per character
`timescale 1ns/1ps
`default_nettype none
module gpib_listener
    import gpib_listener_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // bus pins, electrical level (low is true)
    input  wire logic [7:0]  dio_n_i,
    input  wire logic        atn_n_i,
    input  wire logic        dav_n_i,
    input  wire logic        ifc_n_i,
    input  wire logic        ren_n_i,
    output logic             nrfd_n_o,
    output logic             nrfd_oe_o,
    output logic             ndac_n_o,
    output logic             ndac_oe_o,
    // instrument control lines
    output logic             remote_o,
    output logic             remote_marker_en_n_o,
    output logic             mode_sel_en_o,
    output logic [3:0]       mode_sel_n_o,
    output logic             remote_tuning_enable_line_o,
    output logic             data_strobe_o
);
    typedef struct packed {
        hs_state_t   hs;
        logic [9:0]  cnt;
        logic        xfer;
        logic        strobe;
        logic [7:0]  strobe_cnt;
        logic        listen;
        logic        remote;
        logic        marker;
        logic        mode_armed;
        logic        mode_en;
        logic [3:0]  mode_sel_n;
        logic        tune_en;
        logic [4:0]  my_addr;
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  rx;
        logic        rx_atn;
    } state_t;

    state_t      s_q;
    state_t      s_d;
    logic        atn;
    logic        hs_en_n;
    logic [7:0]  chr;
    logic        addr_match;
    logic        dec_listen;
    logic        dec_unlisten;
    logic        dec_rmk;
    logic        dec_lmk;
    logic        dec_mode;
    logic        dec_digit;
    logic [3:0]  dec_onehot;
    logic        dly_strobe;
    logic        wb_req;
    logic        fifo_out_valid;
    logic        fifo_pop;
    logic [7:0]  fifo_out_data;

    char_stream_if #(.W(8)) acc_if ();

    // transceivers invert the bus: low on a line is a true bit
    assign chr     = ~dio_n_i;                                         // RULE_02
    assign atn     = !atn_n_i;
    assign hs_en_n = !(atn || s_q.listen);                             // RULE_01

    // the decoder does both command and data mode; it sees the byte latched at
    // acceptance, since the controller may move the lines once it sees the accept
    char_decoder u_dec (
        .atn_i         (s_q.rx_atn),
        .char_i        (s_q.rx[6:0]),
        .my_addr_i     (s_q.my_addr),
        .addr_match_o  (addr_match),
        .listen_o      (dec_listen),
        .unlisten_o    (dec_unlisten),
        .remote_mk_o   (dec_rmk),
        .local_mk_o    (dec_lmk),
        .mode_o        (dec_mode),
        .digit_o       (dec_digit),
        .mode_onehot_o (dec_onehot)
    );

    // accepted data characters queue for software; a full queue stalls acceptance
    assign acc_if.data  = s_q.rx;
    assign acc_if.valid = s_q.strobe && !s_q.rx_atn && (s_q.strobe_cnt == 8'd0);

    char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_if       (acc_if),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out_data)
    );

    // handshake pins: drive only while enabled
    assign nrfd_oe_o = !hs_en_n;                                       // RULE_02
    assign ndac_oe_o = !hs_en_n;                                       // RULE_02
    // before acceptance: not ready false while the queue has room, not accepted true
    assign nrfd_n_o  = !s_q.xfer && acc_if.ready;                      // RULE_03
    assign ndac_n_o  = s_q.xfer;                                       // RULE_03

    assign dly_strobe = s_q.strobe && s_q.mode_armed;                  // RULE_14

    assign wb_req   = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign fifo_pop = wb_req && !wb_we_i && (wb_adr_i == REG_DATA);

    // outputs from flip-flops
    assign wb_ack_o                    = s_q.ack;
    assign wb_dat_o                    = s_q.rdata;
    assign remote_o                    = s_q.remote;
    assign remote_marker_en_n_o        = !s_q.marker;                  // RULE_12
    assign mode_sel_en_o               = s_q.mode_en;
    assign mode_sel_n_o                = s_q.mode_sel_n;
    assign remote_tuning_enable_line_o = s_q.tune_en;
    assign data_strobe_o               = s_q.strobe;

    // next state
    always_comb begin
        s_d     = s_q;
        s_d.ack = 1'b0;

        // acceptor handshake; a full queue holds off the settle count
        case (s_q.hs)
            HS_IDLE: begin
                if (!dav_n_i && !hs_en_n && acc_if.ready) begin
                    s_d.hs  = HS_SETTLE;
                    s_d.cnt = '0;
                end
            end
            HS_SETTLE: begin
                if (dav_n_i) begin
                    s_d.hs = HS_IDLE;
                end else if (s_q.cnt == 10'(SETTLE_CYCLES - 1)) begin
                    s_d.hs         = HS_ACCEPTED;                      // RULE_03
                    s_d.xfer       = 1'b1;                             // RULE_03
                    s_d.strobe     = s_q.listen || atn;                // RULE_06
                    s_d.strobe_cnt = 8'(STROBE_CYCLES - 1);
                    s_d.rx         = chr;
                    s_d.rx_atn     = atn;
                end else begin
                    s_d.cnt = s_q.cnt + 10'd1;
                end
            end
            HS_ACCEPTED: begin
                if (dav_n_i) begin
                    s_d.hs   = HS_IDLE;                                // RULE_04
                    s_d.xfer = 1'b0;                                   // RULE_04
                end
            end
            default: s_d.hs = HS_IDLE;
        endcase

        // strobe width counter; trailing edge captures the M marker
        if (s_q.strobe) begin
            if (s_q.strobe_cnt == 8'd0) begin
                s_d.strobe     = 1'b0;
                s_d.mode_armed = dec_mode;                             // RULE_14
            end else begin
                s_d.strobe_cnt = s_q.strobe_cnt - 8'd1;
            end
        end

        // strobe-timed state, sampled on its last cycle
        if (s_q.strobe && s_q.strobe_cnt == 8'd0) begin
            if (addr_match && !dec_unlisten) begin
                s_d.listen = 1'b1;                                     // RULE_07
            end else if (!addr_match && dec_unlisten) begin
                s_d.listen = 1'b0;                                     // RULE_07
            end
            if (dec_rmk) begin
                s_d.marker = 1'b1;                                     // RULE_11
            end else if (dec_lmk) begin
                s_d.marker = 1'b0;                                     // RULE_11
            end
            if (dly_strobe) begin
                s_d.tune_en = dec_digit;                               // RULE_16
                // a non-digit after M leaves the lines alone, never enabled with none low
                if (dec_digit) begin
                    s_d.mode_en    = 1'b1;                             // RULE_15
                    s_d.mode_sel_n = ~dec_onehot;                      // RULE_15
                end
            end
        end

        // remote state: REN is the only way back to local
        if (ren_n_i) begin
            s_d.remote     = 1'b0;                                     // RULE_10
            s_d.marker     = 1'b0;                                     // RULE_12
            s_d.mode_en    = 1'b0;
            s_d.mode_sel_n = MODE_SEL_RST_N;
        end else if (addr_match || s_q.strobe) begin
            s_d.remote = 1'b1;                                         // RULE_09
        end
        // entering remote holds local mode select off until a delayed strobe
        if (!ren_n_i && !s_q.remote && s_d.remote) begin
            s_d.mode_en = 1'b0;                                        // RULE_13
        end

        // interface clear wins over any strobe
        if (!ifc_n_i) begin
            s_d.listen = 1'b0;                                         // RULE_08
        end

        // wishbone slave, answer one cycle after request
        if (wb_req) begin
            s_d.ack   = 1'b1;
            s_d.rdata = '0;
            case (wb_adr_i)
                REG_CTRL: begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.my_addr = wb_dat_i[CTRL_ADDR_LSB +: 5];
                    end
                    s_d.rdata[CTRL_ADDR_LSB +: 5] = s_q.my_addr;
                end
                REG_STATUS: begin
                    s_d.rdata[ST_LISTEN]     = s_q.listen;
                    s_d.rdata[ST_REMOTE]     = s_q.remote;
                    s_d.rdata[ST_MARKER]     = s_q.marker;
                    s_d.rdata[ST_MODE_EN]    = s_q.mode_en;
                    s_d.rdata[ST_TUNE_EN]    = s_q.tune_en;
                    s_d.rdata[ST_FIFO_VALID] = fifo_out_valid;
                end
                REG_DATA: begin
                    s_d.rdata[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
                end
                default: s_d.rdata = '0;
            endcase
        end
    end

    // single register for all state but the queue's; power loss is modelled by rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q            <= '0;                                      // RULE_08
            s_q.hs         <= HS_IDLE;
            s_q.my_addr    <= CTRL_ADDR_RST;
            s_q.mode_sel_n <= MODE_SEL_RST_N;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// *** testbench/gpib_listener_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_listener_properties (
    // clock, reset and host bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // bus lines from the controller
    input wire logic       atn_n_i,
    input wire logic       dav_n_i,
    input wire logic       ren_n_i,
    // listener outputs
    input wire logic       nrfd_n_o,
    input wire logic       nrfd_oe_o,
    input wire logic       ndac_n_o,
    input wire logic       ndac_oe_o,
    input wire logic       remote_o,
    input wire logic       remote_marker_en_n_o,
    input wire logic       mode_sel_en_o,
    input wire logic [3:0] mode_sel_n_o,
    input wire logic       data_strobe_o
);
    // settle window in cycles, a little slack for input registering
    localparam int SET_LO = 497;
    localparam int SET_HI = 753;
    logic [9:0] dav_q;
    logic [7:0] stb_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // dav low time saturates so a stuck line cannot wrap into the window
    always_ff @(posedge clk_i) begin
        if (rst_i || dav_n_i) begin
            dav_q <= 10'h000;
        end else if (dav_q != 10'h3ff) begin
            dav_q <= dav_q + 10'h001;
        end
        if (rst_i || !data_strobe_o) begin
            stb_q <= 8'h00;
        end else begin
            stb_q <= stb_q + 8'h01;
        end
    end

    sequence accepted_s;
        ndac_n_o && !nrfd_n_o;
    endsequence
    sequence released_s;
        !ndac_n_o;
    endsequence

    chk_oe_paired: assert property (nrfd_oe_o == ndac_oe_o)
        else $error("handshake enables differ");
    chk_atn_enables: assert property ($fell(atn_n_i) |-> ##[0:2] nrfd_oe_o)
        else $error("attention did not enable handshake");
    chk_settle_time: assert property ($rose(data_strobe_o) |-> dav_q >= SET_LO && dav_q <= SET_HI)
        else $error("accept outside settle window");
    chk_accept_lines: assert property ($rose(data_strobe_o) |-> accepted_s)
        else $error("strobe without accept levels");
    chk_hold_dav: assert property (ndac_n_o && !dav_n_i |=> ndac_n_o)
        else $error("accept dropped while data valid");
    chk_dav_release: assert property ($rose(dav_n_i) |-> ##[1:2] released_s)
        else $error("handshake not released");
    chk_strobe_width: assert property ($fell(data_strobe_o) |-> stb_q == 8'd75)
        else $error("strobe width wrong");
    chk_remote_held: assert property (remote_o && !ren_n_i |=> remote_o)
        else $error("remote lost while enabled");
    chk_remote_drop: assert property ($rose(ren_n_i) |-> ##[1:2] (!remote_o && remote_marker_en_n_o))
        else $error("local not restored");
    chk_mode_onehot: assert property (mode_sel_en_o |-> $onehot(~mode_sel_n_o))
        else $error("mode lines not one-hot");
    chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");
endmodule

bind gpib_listener gpib_listener_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .atn_n_i(atn_n_i), .dav_n_i(dav_n_i), .ren_n_i(ren_n_i),
    .nrfd_n_o(nrfd_n_o), .nrfd_oe_o(nrfd_oe_o), .ndac_n_o(ndac_n_o),
    .ndac_oe_o(ndac_oe_o), .remote_o(remote_o),
    .remote_marker_en_n_o(remote_marker_en_n_o), .mode_sel_en_o(mode_sel_en_o),
    .mode_sel_n_o(mode_sel_n_o), .data_strobe_o(data_strobe_o)
);
`default_nettype wire

// *** testbench/gpib_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_ctrl_model (
    // clock
    input  wire logic       clk_i,
    // handshake drive from the listener
    input  wire logic       nrfd_n_i,
    input  wire logic       nrfd_oe_i,
    input  wire logic       ndac_n_i,
    input  wire logic       ndac_oe_i,
    // controller lines, electrical level
    output logic [7:0]      dio_n_o,
    output logic            atn_n_o,
    output logic            dav_n_o
);
    logic nrfd_w;
    logic ndac_w;

    // terminated lines float high when nobody pulls them
    assign nrfd_w = nrfd_oe_i ? nrfd_n_i : 1'b1;
    assign ndac_w = ndac_oe_i ? ndac_n_i : 1'b1;

    initial begin
        dio_n_o = 8'hff;
        atn_n_o = 1'b1;
        dav_n_o = 1'b1;
    end

    // one byte; ok falls if the listener never answers
    task automatic send(input logic [7:0] ch, input logic cmd, output bit ok);
        int n;
        n = 0;
        @(posedge clk_i);
        dio_n_o <= ~ch;
        atn_n_o <= ~cmd;
        do begin @(posedge clk_i); n++; end while (!nrfd_w && n < 3000);
        dav_n_o <= 1'b0;
        do begin @(posedge clk_i); n++; end while (!ndac_w && n < 3000);
        dav_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        dio_n_o <= 8'hff;
        atn_n_o <= 1'b1;
        ok = (n < 3000);
    endtask
endmodule
`default_nettype wire

// *** testbench/gpib_listener_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module gpib_listener_tb_top;
    import gpib_listener_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [3:0]  wb_adr = 4'h0;
    logic [31:0] wb_dw = 32'h0;
    logic [31:0] wb_dr;
    logic        wb_ack;
    logic [7:0]  dio_n;
    logic        atn_n;
    logic        dav_n;
    logic        ifc_n = 1'b1;
    logic        ren_n = 1'b1;
    logic        nrfd_n, nrfd_oe, ndac_n, ndac_oe;
    logic        remote, mk_en_n, mode_en, tune, strobe;
    logic [3:0]  mode_n;
    logic [31:0] seed = 32'h41192b07;
    logic [31:0] d;
    logic [7:0]  exp_q[$];
    logic [7:0]  c;
    logic [4:0]  addr;
    int          fails = 0;
    int          checked = 0;

    always #2 clk = ~clk;

    gpib_listener #(.FIFO_DEPTH(8)) DUT (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr),
        .wb_ack_o(wb_ack), .dio_n_i(dio_n), .atn_n_i(atn_n), .dav_n_i(dav_n),
        .ifc_n_i(ifc_n), .ren_n_i(ren_n), .nrfd_n_o(nrfd_n), .nrfd_oe_o(nrfd_oe),
        .ndac_n_o(ndac_n), .ndac_oe_o(ndac_oe), .remote_o(remote),
        .remote_marker_en_n_o(mk_en_n), .mode_sel_en_o(mode_en), .mode_sel_n_o(mode_n),
        .remote_tuning_enable_line_o(tune), .data_strobe_o(strobe)
    );
    gpib_ctrl_model ctl (
        .clk_i(clk), .nrfd_n_i(nrfd_n), .nrfd_oe_i(nrfd_oe), .ndac_n_i(ndac_n),
        .ndac_oe_i(ndac_oe), .dio_n_o(dio_n), .atn_n_o(atn_n), .dav_n_o(dav_n)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // listen command: group bits 01 over the five address bits
    function automatic logic [7:0] listen_char(input logic [4:0] a);
        return {1'b0, LISTEN_GROUP, a};
    endfunction

    task automatic report_and_stop();
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dw <= wd;
        do begin @(posedge clk); n++; end while (wb_ack !== 1'b1 && n < 50);
        d = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) begin fails++; report_and_stop(); end
    endtask

    task automatic put(input logic [7:0] ch, input logic cmd);
        bit ok;
        ctl.send(ch, cmd, ok);
        if (!ok) begin fails++; report_and_stop(); end
        if (!cmd) exp_q.push_back(ch);
        // strobe-timed state and the buffer update only at the strobe's end
        repeat (STROBE_CYCLES + 2) @(posedge clk);
    endtask

    // empty the buffer and compare in arrival order, bus data inverted back
    task automatic drain();
        while (exp_q.size() > 0) begin
            wb(1'b0, REG_DATA, 32'h0);
            `CHK("fifo_data", exp_q.pop_front(), d[7:0])
        end
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK("fifo_valid", 1'b0, d[ST_FIFO_VALID])
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("mode_n_rst", 4'hf, mode_n)
        `CHK("marker_rst", 1'b1, mk_en_n)
        `CHK("oe_rst", 1'b0, nrfd_oe)
        seed = lfsr(seed);
        addr = (seed[4:0] == 5'h1f) ? 5'h1e : seed[4:0];
        wb(1'b1, REG_CTRL, {27'h0, addr});
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl", addr, d[4:0])
        wb(1'b0, 4'hc, 32'h0);
        `CHK("unmapped", 32'h0, d)
        ren_n <= 1'b0;
        // another unit's address must not make us listen
        put(listen_char((addr == 5'h00) ? 5'h01 : 5'h00), 1'b1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK("listen_other", 1'b0, d[ST_LISTEN])
        put(listen_char(addr), 1'b1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK("listen", 1'b1, d[ST_LISTEN])
        `CHK("remote", 1'b1, remote)
        `CHK("mode_off", 1'b0, mode_en)
        put(CHAR_REMOTE_MK, 1'b0);
        `CHK("marker_on", 1'b0, mk_en_n)
        seed = lfsr(seed);
        put(CHAR_MODE, 1'b0);
        put(CHAR_DIGIT1 + {5'h0, seed[1:0]}, 1'b0);
        `CHK("mode_on", 1'b1, mode_en)
        `CHK("mode_one", 1'b1, $onehot(~mode_n))
        `CHK("mode_sel", ~(4'h1 << seed[1:0]), mode_n)
        `CHK("tune", 1'b1, tune)
        put(CHAR_LOCAL_MK, 1'b0);
        `CHK("marker_off", 1'b1, mk_en_n)
        put(CHAR_REMOTE_MK, 1'b0);
        drain();
        // fill the buffer until it refuses, then empty it
        repeat (8) begin
            seed = lfsr(seed);
            put({1'b0, seed[6:0]}, 1'b0);
        end
        repeat (2) @(posedge clk);
        `CHK("full_nrfd", 1'b0, nrfd_n)
        drain();
        repeat (2) @(posedge clk);
        `CHK("ready_nrfd", 1'b1, nrfd_n)
        put(CHAR_UNLISTEN, 1'b1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK("unlisten", 1'b0, d[ST_LISTEN])
        `CHK("oe_idle", 1'b0, nrfd_oe)
        put(listen_char(addr), 1'b1);
        @(posedge clk);
        ifc_n <= 1'b0;
        repeat (2) @(posedge clk);
        ifc_n <= 1'b1;
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK("ifc_clear", 1'b0, d[ST_LISTEN])
        `CHK("remote_kept", 1'b1, remote)
        ren_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("local", 1'b0, remote)
        `CHK("marker_local", 1'b1, mk_en_n)
        report_and_stop();
    end
endmodule
`default_nettype wire
